// [rtl/hmcs_pkg.sv]
/*
  Package for the measurement cycle sequencer: modes, channel sets, timing.
  Assumes a 20 MHz system clock.
*/
package hmcs_pkg;
  localparam int CLOCK_MHZ = 20;
  // Field conversion time in microseconds, least / typical / most
  localparam int CONV_MIN_US = 32;
  localparam int CONV_TYP_US = 43;
  localparam int CONV_MAX_US = 54;
  localparam int CONV_MIN_CYC = CONV_MIN_US * CLOCK_MHZ;
  localparam int CONV_MAX_CYC = CONV_MAX_US * CLOCK_MHZ;
  localparam int CONV_TYP_CYC = CONV_TYP_US * CLOCK_MHZ;
  localparam int CNT_W = 11;
  localparam int DATA_W = 12;

  typedef enum logic [1:0] {
    HMCS_MODE_FAST = 2'h0,
    HMCS_MODE_LOWPOWER = 2'h1,
    HMCS_MODE_HOST = 2'h2,
    HMCS_MODE_DOWN = 2'h3
  } hmcs_mode_t;

  typedef enum logic [1:0] {
    HMCS_CFG_XYZT = 2'h0,
    HMCS_CFG_XYZ = 2'h1,
    HMCS_CFG_XY = 2'h2
  } hmcs_cfg_t;

  typedef enum logic [1:0] {
    HMCS_CH_X = 2'h0,
    HMCS_CH_Y = 2'h1,
    HMCS_CH_Z = 2'h2,
    HMCS_CH_T = 2'h3
  } hmcs_chan_t;

  typedef struct packed {
    logic [DATA_W-1:0] xField;
    logic [DATA_W-1:0] yField;
    logic [DATA_W-1:0] zField;
    logic [DATA_W-1:0] temp;
  } hmcs_result_t;
endpackage

// [rtl/hmcs_conv_timer.sv]
/*
  Conversion timer: after start, counts the conversion time and pulses done.
  Assumes start arrives only while idle.
*/
`timescale 1ns/1ps
module hmcs_conv_timer #(
  parameter int CYCLES = hmcs_pkg::CONV_TYP_CYC
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic start, // One-cycle start pulse
  output logic busy, // Conversion running
  output logic done // One-cycle end pulse
);
  // Refuse lengths outside the converter window at elaboration
  if (CYCLES < hmcs_pkg::CONV_MIN_CYC || CYCLES > hmcs_pkg::CONV_MAX_CYC)
    $error("Conversion time out of range");

  logic [hmcs_pkg::CNT_W-1:0] count_reg;
  logic [hmcs_pkg::CNT_W-1:0] count_next;
  logic busy_reg;
  wire lastCycle = busy_reg && (count_reg == hmcs_pkg::CNT_W'(CYCLES - 1));
  assign count_next = busy_reg ? count_reg + 1'b1 : '0;
  assign busy = busy_reg;
  assign done = lastCycle;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      busy_reg <= 1'b0;
      count_reg <= '0;
    end
    else
    begin
      count_reg <= lastCycle ? '0 : count_next;
      busy_reg <= start | (busy_reg & ~lastCycle);
    end
  end

  // Once started, busy must not drop in the first few cycles
  a_conv_length: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(busy_reg) |-> busy_reg [*8])
    else $error("Conversion ended too early");
endmodule

// [rtl/hmcs_sequencer.sv]
/*
  Measurement cycle sequencer: converts X, Y, Z and temperature in order,
  picks the channel set, ends the cycle and starts the next per mode.
  Assumes trigger inputs are pulses on the system clock; the field
  samples come from the converter front end on the same clock.
*/
`timescale 1ns/1ps
// Summary of operation
// - Fast mode restarts a new cycle immediately after previous one ends.
// - Low-power mode starts a cycle only on internal or external trigger.
// - Four-channel set ends the cycle after temperature conversion.
// - Three-channel set skips temperature, keeps it, ends after Z.
// - Angular set converts X and Y only, keeps Z and temperature.
// - Host mode starts a measurement only on a host bus trigger.
// - Each field conversion takes 32 to 54 us, typically 43.
module hmcs_sequencer #(
  parameter int CONV_CYCLES = hmcs_pkg::CONV_TYP_CYC
) (
  input wire logic clock, // 20 MHz system clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire hmcs_pkg::hmcs_mode_t mode, // Operating mode
  input wire hmcs_pkg::hmcs_cfg_t chanCfg, // Channel set
  input wire logic intTrigger, // Internal timer trigger pulse
  input wire logic hostTrigger, // Host bus trigger pulse
  input wire logic [hmcs_pkg::DATA_W-1:0] adcSample, // Converter sample
  output hmcs_pkg::hmcs_result_t results, // Latest results
  output hmcs_pkg::hmcs_chan_t activeChan, // Channel converting
  output logic converting, // A conversion is running
  output logic cycleDone // One-cycle pulse at end of cycle
);
  // The length counter of the timing checks must hold the longest conversion
  if (hmcs_pkg::CONV_MAX_CYC >= (1 << hmcs_pkg::CNT_W))
    $error("Length counter too narrow for the longest conversion");

  typedef enum logic [1:0] {
    HMCS_IDLE = 2'b00,
    HMCS_CONV = 2'b01,
    HMCS_NEXT = 2'b11
  } hmcs_state_t;

  hmcs_state_t state_reg;
  hmcs_state_t state_next;
  hmcs_pkg::hmcs_chan_t chan_reg;
  hmcs_pkg::hmcs_chan_t chan_next;
  hmcs_pkg::hmcs_result_t results_reg;
  logic done_reg;
  logic convStart;
  logic convBusy;
  logic convDone;

  // Start condition per mode
  wire trigFast = (mode == hmcs_pkg::HMCS_MODE_FAST);
  wire trigLow = (mode == hmcs_pkg::HMCS_MODE_LOWPOWER) && (intTrigger || hostTrigger);
  wire trigHost = (mode == hmcs_pkg::HMCS_MODE_HOST) && hostTrigger;
  wire startCycle = trigFast || trigLow || trigHost;

  // Last channel of the configured set
  wire hmcs_pkg::hmcs_chan_t lastChan =
    (chanCfg == hmcs_pkg::HMCS_CFG_XY) ? hmcs_pkg::HMCS_CH_Y :
    (chanCfg == hmcs_pkg::HMCS_CFG_XYZ) ? hmcs_pkg::HMCS_CH_Z : hmcs_pkg::HMCS_CH_T;
  wire isLast = (chan_reg == lastChan);
  // Fixed order X, Y, Z, T
  wire hmcs_pkg::hmcs_chan_t incChan = hmcs_pkg::hmcs_chan_t'(chan_reg + 2'h1);

  always_comb
  begin
    state_next = state_reg;
    chan_next = chan_reg;
    convStart = 1'b0;
    unique case (state_reg)
      HMCS_IDLE:
      begin
        if (startCycle)
        begin
          state_next = HMCS_CONV;
          chan_next = hmcs_pkg::HMCS_CH_X;
          convStart = 1'b1;
        end
      end
      HMCS_CONV:
      begin
        if (convDone)
          state_next = HMCS_NEXT;
      end
      HMCS_NEXT:
      begin
        if (isLast)
        begin
          // Fast mode goes straight into the next cycle
          state_next = trigFast ? HMCS_CONV : HMCS_IDLE;
          chan_next = hmcs_pkg::HMCS_CH_X;
          convStart = trigFast;
        end
        else
        begin
          state_next = HMCS_CONV;
          chan_next = incChan;
          convStart = 1'b1;
        end
      end
      default:
        state_next = HMCS_IDLE;
    endcase
  end

  hmcs_conv_timer #(.CYCLES(CONV_CYCLES)) convTimer (
    .clock(clock),
    .rst_n(rst_n),
    .start(convStart),
    .busy(convBusy),
    .done(convDone)
  );

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_reg <= HMCS_IDLE;
      chan_reg <= hmcs_pkg::HMCS_CH_X;
      results_reg <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      chan_reg <= chan_next;
      done_reg <= (state_reg == HMCS_NEXT) && isLast;
      // Only the converted channel updates; skipped ones hold
      if (convDone)
      begin
        unique case (chan_reg)
          hmcs_pkg::HMCS_CH_X: results_reg.xField <= adcSample;
          hmcs_pkg::HMCS_CH_Y: results_reg.yField <= adcSample;
          hmcs_pkg::HMCS_CH_Z: results_reg.zField <= adcSample;
          hmcs_pkg::HMCS_CH_T: results_reg.temp <= adcSample;
        endcase
      end
    end
  end

  assign results = results_reg;
  assign activeChan = chan_reg;
  assign converting = convBusy;
  assign cycleDone = done_reg;

  // Length of the running conversion, counted apart from the timer so that a
  // timer fault cannot hide behind its own count; saturates instead of wrapping.
  localparam int LEN_LO_I = hmcs_pkg::CONV_MIN_CYC - 1;
  localparam int LEN_HI_I = hmcs_pkg::CONV_MAX_CYC - 1;
  localparam logic [hmcs_pkg::CNT_W-1:0] LEN_LO = LEN_LO_I[hmcs_pkg::CNT_W-1:0];
  localparam logic [hmcs_pkg::CNT_W-1:0] LEN_HI = LEN_HI_I[hmcs_pkg::CNT_W-1:0];
  logic [hmcs_pkg::CNT_W-1:0] convLen_reg;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      convLen_reg <= '0;
    else if (!convBusy)
      convLen_reg <= '0;
    else if (convLen_reg != '1)
      convLen_reg <= convLen_reg + 1'b1;
  end

  a_fast_restart: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == HMCS_NEXT && isLast && trigFast) |=> (state_reg == HMCS_CONV))
    else $error("Fast mode did not restart");
  a_fast_gap: assert property (@(posedge clock) disable iff (!rst_n)
    (convDone ##1 trigFast) |=> convBusy)
    else $error("Fast mode left more than one idle cycle");
  a_trigger_needed: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == HMCS_IDLE && !startCycle) |=> (state_reg == HMCS_IDLE))
    else $error("Cycle started without trigger");
  a_down_idle: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == HMCS_IDLE && mode == hmcs_pkg::HMCS_MODE_DOWN)
      |=> (state_reg == HMCS_IDLE))
    else $error("Power down mode started a cycle");
  a_cycle_locked: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == HMCS_CONV && !convDone) |=> (state_reg == HMCS_CONV))
    else $error("Running conversion left early");
  a_host_only: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == HMCS_IDLE && mode == hmcs_pkg::HMCS_MODE_HOST && !hostTrigger)
      |=> !convBusy)
    else $error("Host mode started without host trigger");
  a_host_waits: assert property (@(posedge clock) disable iff (!rst_n)
    (state_reg == HMCS_IDLE && mode == hmcs_pkg::HMCS_MODE_HOST && !hostTrigger)
      |=> (state_reg == HMCS_IDLE))
    else $error("Host mode left idle without host trigger");
  a_full_end_temp: assert property (@(posedge clock) disable iff (!rst_n)
    (cycleDone && $stable(chanCfg) && chanCfg == hmcs_pkg::HMCS_CFG_XYZT)
      |-> $past(chan_reg, 2) == hmcs_pkg::HMCS_CH_T)
    else $error("Four-channel cycle did not end on temperature");
  a_done_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    cycleDone |=> !cycleDone)
    else $error("Cycle end pulse longer than one cycle");
  a_three_keep_temp: assert property (@(posedge clock) disable iff (!rst_n)
    (chanCfg == hmcs_pkg::HMCS_CFG_XYZ) |-> chan_reg != hmcs_pkg::HMCS_CH_T)
    else $error("Temperature converted in three-channel set");
  a_three_end_z: assert property (@(posedge clock) disable iff (!rst_n)
    (cycleDone && $stable(chanCfg) && chanCfg == hmcs_pkg::HMCS_CFG_XYZ)
      |-> $past(chan_reg) == hmcs_pkg::HMCS_CH_Z)
    else $error("Three-channel cycle did not end on Z");
  a_three_hold_t: assert property (@(posedge clock) disable iff (!rst_n)
    (chanCfg == hmcs_pkg::HMCS_CFG_XYZ && $stable(chanCfg))
      |-> $stable(results_reg.temp))
    else $error("Three-channel set changed temperature");
  a_angle_keep_z: assert property (@(posedge clock) disable iff (!rst_n)
    (chanCfg == hmcs_pkg::HMCS_CFG_XY && $stable(chanCfg))
      |-> $stable(results_reg.zField) && $stable(results_reg.temp))
    else $error("Angular set changed Z or temperature");
  a_angle_end_y: assert property (@(posedge clock) disable iff (!rst_n)
    (cycleDone && $stable(chanCfg) && chanCfg == hmcs_pkg::HMCS_CFG_XY)
      |-> $past(chan_reg) == hmcs_pkg::HMCS_CH_Y)
    else $error("Angular cycle did not end on Y");
  a_chan_order: assert property (@(posedge clock) disable iff (!rst_n)
    (convStart && state_reg == HMCS_NEXT && !isLast)
      |=> chan_reg == hmcs_pkg::hmcs_chan_t'($past(chan_reg) + 2'h1))
    else $error("Channel order broken");
  a_conv_time: assert property (@(posedge clock) disable iff (!rst_n)
    convDone |-> (convLen_reg >= LEN_LO && convLen_reg <= LEN_HI))
    else $error("Conversion time outside the allowed window");
  a_conv_bound: assert property (@(posedge clock) disable iff (!rst_n)
    convBusy |-> convLen_reg <= LEN_HI)
    else $error("Conversion ran past the longest allowed time");
endmodule

// [verification/hmcs_host_model.sv]
/*
  Host model: turns a request into a trigger pulse and feeds samples.
  Assumes the same clock as the sequencer.
*/
`timescale 1ns/1ps
module hmcs_host_model (
  input wire logic clock, // System clock
  input wire logic fire, // Request a trigger
  input wire logic [11:0] base, // Sample base, low bits zero
  input wire hmcs_pkg::hmcs_chan_t chan, // Channel converting
  output logic hostTrigger, // Trigger pulse
  output logic [11:0] sample // Sample value
);
  // Channel code in low bits shows which channel wrote each result
  assign sample = base | {10'h000, chan};
  always_ff @(posedge clock)
    hostTrigger <= fire;
endmodule

// [verification/test_hall_measurement_cycle_sequencer.sv]
/*
  Bench for the measurement cycle sequencer.
  Assumes the host model file and default conversion length.
*/
`timescale 1ns/1ps
module test_hall_measurement_cycle_sequencer;
  logic clock = 0;
  logic rst_n = 0;
  hmcs_pkg::hmcs_mode_t mode = hmcs_pkg::HMCS_MODE_HOST;
  hmcs_pkg::hmcs_cfg_t chanCfg = hmcs_pkg::HMCS_CFG_XYZT;
  logic intTrigger = 0;
  logic fire = 0;
  logic [11:0] base = 12'h000;
  logic hostTrigger, converting, cycleDone;
  logic [11:0] sample;
  hmcs_pkg::hmcs_result_t res, expRes;
  hmcs_pkg::hmcs_chan_t activeChan;
  int num_errors = 0;
  int compares = 0;
  always #25 clock = ~clock;
  hmcs_host_model host (.clock(clock), .fire(fire), .base(base), .chan(activeChan),
    .hostTrigger(hostTrigger), .sample(sample));
  hmcs_sequencer dut (.clock(clock), .rst_n(rst_n), .mode(mode), .chanCfg(chanCfg),
    .intTrigger(intTrigger), .hostTrigger(hostTrigger), .adcSample(sample),
    .results(res), .activeChan(activeChan), .converting(converting),
    .cycleDone(cycleDone));
  task results;
    $display("TB: errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Counts done pulses and busy cycles over a fixed span
  task watch(input int span, output int dones, output int busy);
    dones = 0;
    busy = 0;
    repeat (span)
    begin
      @(posedge clock);
      #1;
      dones += (cycleDone === 1'b1);
      busy += (converting === 1'b1);
    end
  endtask
  localparam hmcs_pkg::hmcs_mode_t LOW = hmcs_pkg::HMCS_MODE_LOWPOWER;
  localparam hmcs_pkg::hmcs_mode_t HOST = hmcs_pkg::HMCS_MODE_HOST;
  task measure(input hmcs_pkg::hmcs_mode_t m, input hmcs_pkg::hmcs_cfg_t c,
    input logic [11:0] b, input int nch, input logic [7:0] ord, input bit useInt);
    int n;
    int busy;
    logic prev;
    logic [7:0] order;
    n = 0;
    busy = 0;
    prev = 0;
    order = 8'h00;
    @(posedge clock);
    mode <= m;
    chanCfg <= c;
    base <= b;
    fire <= !useInt;
    @(posedge clock);
    fire <= 1'b0;
    intTrigger <= useInt;
    // Either trigger reaches the sequencer at this edge, so the first busy cycle follows it
    @(posedge clock);
    intTrigger <= 1'b0;
    #1;
    while (cycleDone !== 1'b1 && n < 5000)
    begin
      if (converting === 1'b1 && prev !== 1'b1)
        order = {order[5:0], 2'(activeChan)};
      busy += (converting === 1'b1);
      prev = converting;
      n++;
      @(posedge clock);
      #1;
    end
    if (n == 5000)
    begin
      chk(48'h0, 48'h1);
      results();
    end
    expRes.xField = b;
    expRes.yField = b | 12'h001;
    if (nch > 2) expRes.zField = b | 12'h002;
    if (nch > 3) expRes.temp = b | 12'h003;
    chk(48'(order), 48'(ord));
    chk(48'(busy), 48'(nch * hmcs_pkg::CONV_TYP_CYC));
    chk(res, expRes);
    $display("test cfg %0d done", nch);
  endtask
  task t_refuse;
    int d, b;
    @(posedge clock);
    intTrigger <= 1'b1;
    @(posedge clock);
    intTrigger <= 1'b0;
    watch(1000, d, b);
    chk(48'(b), 48'h0);
    @(posedge clock);
    mode <= hmcs_pkg::HMCS_MODE_DOWN;
    fire <= 1'b1;
    intTrigger <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    intTrigger <= 1'b0;
    watch(1000, d, b);
    chk(48'(b), 48'h0);
    chk(48'(d), 48'h0);
    $display("test refuse done");
  endtask
  task t_fast;
    int d, b;
    @(posedge clock);
    mode <= hmcs_pkg::HMCS_MODE_FAST;
    chanCfg <= hmcs_pkg::HMCS_CFG_XY;
    watch(6000, d, b);
    // One idle cycle per channel and two channels per cycle, with no trigger wait
    chk(48'(d), 48'((6000 - 1) / (2 * (hmcs_pkg::CONV_TYP_CYC + 1))));
    chk(48'(b), 48'(6000 - 6000 / (hmcs_pkg::CONV_TYP_CYC + 1)));
    $display("test fast done");
  endtask
  initial
  begin
    expRes = '0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    chk(res, 48'h0);
    measure(HOST, hmcs_pkg::HMCS_CFG_XYZT, 12'h100, 4, 8'h1B, 0);
    measure(HOST, hmcs_pkg::HMCS_CFG_XYZ, 12'h200, 3, 8'h06, 0);
    t_refuse();
    measure(LOW, hmcs_pkg::HMCS_CFG_XY, 12'h300, 2, 8'h01, 1);
    measure(LOW, hmcs_pkg::HMCS_CFG_XYZT, 12'h400, 4, 8'h1B, 0);
    t_fast();
    results();
  end
endmodule
